// ==== hw/eiml_int_mask.sv ====
// interrupt masking and combining for the e1 framer: three mask registers,
// the acknowledge and suspend controls, one active-low request pin.
// assumes event strobes and status levels come from ref_clk logic, and the
// register port strobes are synchronous one-cycle pulses on ref_clk.
`default_nettype none

module eiml_int_mask
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [eiml_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [eiml_pkg::DATA_W-1:0] reg_wdata,
    output logic [eiml_pkg::DATA_W-1:0] reg_rdata,
    // receive framing strobes and levels
    input wire logic frame_err_stb,
    input wire logic local_crc_err_stb,
    input wire logic remote_ebit_err_stb,
    input wire logic ts16_alarm_indication,
    input wire logic lcv_err_stb,
    input wire logic prbs_bit_err_stb,
    input wire logic aux_pattern_flag,
    input wire logic remote_alarm_flag,
    // counter overflow strobes
    input wire logic fas_cnt_ovf_stb,
    input wire logic crc_cnt_ovf_stb,
    input wire logic ebit_cnt_ovf_stb,
    input wire logic lcv_cnt_wrap_stb,
    input wire logic prbs_cnt_wrap_stb,
    input wire logic prbs_mf_cnt_ovf_stb,
    input wire logic spare_bit_chg_stb,
    input wire logic spare_nibble_chg_stb,
    input wire logic spare_bit_or_nibble_select,
    // link controllers, jitter fifo, timers, signalling
    input wire logic link_ctrl_a_irq,
    input wire logic link_ctrl_b_irq,
    input wire logic link_ctrl_c_irq,
    input wire logic jitter_near_limit,
    input wire logic one_second_flag,
    input wire logic five_second_flag,
    input wire logic remote_alarm_crc_flag,
    input wire logic sig_change_stb,
    // request pin, three-state
    output logic irq_n_o,
    output logic irq_oe
);
    import eiml_pkg::*;

    logic [DATA_W-1:0] rx_event_int_enable_ff;
    logic [DATA_W-1:0] counter_overflow_int_enable_ff;
    logic [DATA_W-1:0] misc_event_int_enable_ff;
    logic int_suspend_ff;
    logic int_acknowledge_toggle_ff;
    logic [SRC_W-1:0] pend_ff;
    logic irq_n_ff;
    logic [DATA_W-1:0] rdata_ff;

    eiml_edge_if #(.W(EDGE_W)) edge_bus ();

    eiml_rise_det #(.W(EDGE_W)) u_rise
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .edge_io(edge_bus)
    );

    assign edge_bus.level[E_TS16] = ts16_alarm_indication;
    assign edge_bus.level[E_AUX] = aux_pattern_flag;
    assign edge_bus.level[E_RAI] = remote_alarm_flag;
    assign edge_bus.level[E_LINK_A] = link_ctrl_a_irq;
    assign edge_bus.level[E_LINK_B] = link_ctrl_b_irq;
    assign edge_bus.level[E_LINK_C] = link_ctrl_c_irq;
    assign edge_bus.level[E_JITTER] = jitter_near_limit;
    assign edge_bus.level[E_ONE_SEC] = one_second_flag;
    assign edge_bus.level[E_FIVE_SEC] = five_second_flag;
    assign edge_bus.level[E_ALARM_CRC] = remote_alarm_crc_flag;

    // register decode
    wire wr_ctrl = reg_wr && (reg_addr == CTRL_ADDR);
    wire wr_rx = reg_wr && (reg_addr == RX_MASK_ADDR);
    wire wr_cnt = reg_wr && (reg_addr == CNT_MASK_ADDR);
    wire wr_misc = reg_wr && (reg_addr == MISC_MASK_ADDR);

    // either direction of the acknowledge bit counts
    wire ack_clr = wr_ctrl && (reg_wdata[CTRL_ACK_BIT] != int_acknowledge_toggle_ff);

    wire [DATA_W-1:0] ctrl_rd_val = ({{(DATA_W-1){1'b0}}, int_suspend_ff} << CTRL_SUSPEND_BIT)
        | ({{(DATA_W-1){1'b0}}, int_acknowledge_toggle_ff} << CTRL_ACK_BIT);

    wire [DATA_W-1:0] rd_mux =
        (reg_addr == CTRL_ADDR) ? ctrl_rd_val :
        (reg_addr == RX_MASK_ADDR) ? rx_event_int_enable_ff :
        (reg_addr == CNT_MASK_ADDR) ? counter_overflow_int_enable_ff :
        (reg_addr == MISC_MASK_ADDR) ? misc_event_int_enable_ff : READ_IDLE;

    // the bit/nibble selector lives in another control word
    wire spare_chg = spare_bit_or_nibble_select ? spare_bit_chg_stb : spare_nibble_chg_stb;

    wire [DATA_W-1:0] rx_src =
    {
        frame_err_stb,
        local_crc_err_stb,
        remote_ebit_err_stb,
        edge_bus.rise[E_TS16],
        lcv_err_stb,
        prbs_bit_err_stb,
        edge_bus.rise[E_AUX],
        edge_bus.rise[E_RAI]
    };

    wire [DATA_W-1:0] cnt_src =
    {
        fas_cnt_ovf_stb,
        crc_cnt_ovf_stb,
        1'b0,
        ebit_cnt_ovf_stb,
        lcv_cnt_wrap_stb,
        prbs_cnt_wrap_stb,
        prbs_mf_cnt_ovf_stb,
        spare_chg
    };

    wire [DATA_W-1:0] misc_src =
    {
        edge_bus.rise[E_LINK_A],
        edge_bus.rise[E_LINK_B],
        edge_bus.rise[E_LINK_C],
        edge_bus.rise[E_JITTER],
        edge_bus.rise[E_ONE_SEC],
        edge_bus.rise[E_FIVE_SEC],
        edge_bus.rise[E_ALARM_CRC],
        sig_change_stb
    };

    wire [SRC_W-1:0] mask_all = {rx_event_int_enable_ff, counter_overflow_int_enable_ff, misc_event_int_enable_ff};
    wire [SRC_W-1:0] src_all = {rx_src, cnt_src, misc_src};

    // masks gate only the latch; sources keep running regardless
    wire [SRC_W-1:0] set_vec = src_all & mask_all & {SRC_W{~int_suspend_ff}};

    // a set arriving with the acknowledge wins; clearing a mask withdraws its bit
    wire [SRC_W-1:0] keep_vec = pend_ff & mask_all & {SRC_W{~ack_clr}};
    wire [SRC_W-1:0] nxt_pend = keep_vec | set_vec;
    wire nxt_irq_n = ~(|nxt_pend);

    wire [DATA_W-1:0] nxt_rx_mask = wr_rx ? reg_wdata : rx_event_int_enable_ff;
    wire [DATA_W-1:0] nxt_cnt_mask = wr_cnt ? (reg_wdata & CNT_MASK_USED) : counter_overflow_int_enable_ff;
    wire [DATA_W-1:0] nxt_misc_mask = wr_misc ? reg_wdata : misc_event_int_enable_ff;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rx_event_int_enable_ff <= MASK_RESET;
            counter_overflow_int_enable_ff <= MASK_RESET;
            misc_event_int_enable_ff <= MASK_RESET;
        end
        else
        begin
            rx_event_int_enable_ff <= nxt_rx_mask;
            counter_overflow_int_enable_ff <= nxt_cnt_mask;
            misc_event_int_enable_ff <= nxt_misc_mask;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            int_suspend_ff <= 1'b0;
            int_acknowledge_toggle_ff <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            int_suspend_ff <= reg_wdata[CTRL_SUSPEND_BIT];
            int_acknowledge_toggle_ff <= reg_wdata[CTRL_ACK_BIT];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pend_ff <= '0;
            irq_n_ff <= 1'b1;
        end
        else
        begin
            pend_ff <= nxt_pend;
            irq_n_ff <= nxt_irq_n;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rdata_ff <= READ_IDLE;
        else if (reg_rd)
            rdata_ff <= rd_mux;
    end

    assign reg_rdata = rdata_ff;
    assign irq_n_o = irq_n_ff;
    // suspend releases the pin; the board pull-up keeps it high
    assign irq_oe = ~int_suspend_ff;

    // ------------------------------------------------------------------
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_mask_blocks;
        (!rx_event_int_enable_ff[P_FRAME_ERR - RX_BASE] && !pend_ff[P_FRAME_ERR])
            |=> !pend_ff[P_FRAME_ERR];
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked source latched");

    property p_frame_err;
        (frame_err_stb && rx_event_int_enable_ff[P_FRAME_ERR - RX_BASE] && !int_suspend_ff)
            |=> pend_ff[P_FRAME_ERR] && !irq_n_o;
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("frame error did not raise request");

    property p_local_crc;
        (local_crc_err_stb && rx_event_int_enable_ff[P_LOCAL_CRC - RX_BASE] && !int_suspend_ff)
            ##1 (!ack_clr && rx_event_int_enable_ff[P_LOCAL_CRC - RX_BASE]) |=> pend_ff[P_LOCAL_CRC] && !irq_n_o;
    endproperty
    a_local_crc: assert property (p_local_crc) else $error("crc error lost before acknowledge");

    property p_lcv_wrap;
        (lcv_cnt_wrap_stb && counter_overflow_int_enable_ff[P_LCV_WRAP - CNT_BASE] && !int_suspend_ff)
            |=> pend_ff[P_LCV_WRAP];
    endproperty
    a_lcv_wrap: assert property (p_lcv_wrap) else $error("lcv wrap not latched");

    property p_prbs_wrap;
        (!prbs_cnt_wrap_stb && !pend_ff[P_PRBS_WRAP]) |=> !pend_ff[P_PRBS_WRAP];
    endproperty
    a_prbs_wrap: assert property (p_prbs_wrap) else $error("pattern wrap latched with no wrap");

    property p_spare_sel;
        (!spare_bit_or_nibble_select && spare_bit_chg_stb && !spare_nibble_chg_stb && !pend_ff[P_SPARE])
            |=> !pend_ff[P_SPARE];
    endproperty
    a_spare_sel: assert property (p_spare_sel) else $error("bit change taken in nibble mode");

    property p_link_a;
        (edge_bus.rise[E_LINK_A] && misc_event_int_enable_ff[P_LINK_A - MISC_BASE] && !int_suspend_ff)
            |=> pend_ff[P_LINK_A] && !irq_n_o;
    endproperty
    a_link_a: assert property (p_link_a) else $error("link controller event dropped");

    property p_one_sec;
        (!one_second_flag ##1 one_second_flag && misc_event_int_enable_ff[P_ONE_SEC - MISC_BASE]
            && !int_suspend_ff) |=> pend_ff[P_ONE_SEC];
    endproperty
    a_one_sec: assert property (p_one_sec) else $error("one-second rise missed");

    property p_sig;
        (sig_change_stb && misc_event_int_enable_ff[P_SIG - MISC_BASE] && !int_suspend_ff)
            |=> !irq_n_o;
    endproperty
    a_sig: assert property (p_sig) else $error("signalling change did not raise request");

    property p_ack;
        (ack_clr && !(|set_vec)) |=> irq_n_o && (pend_ff == '0);
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge did not release request");

    property p_suspend;
        int_suspend_ff |-> !irq_oe ##1 ((pend_ff & ~$past(pend_ff)) == '0);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspended block took a source");

    property p_pend_holds;
        (pend_ff[P_FRAME_ERR] && rx_event_int_enable_ff[P_FRAME_ERR - RX_BASE] && !ack_clr)
            |=> pend_ff[P_FRAME_ERR] && !irq_n_o;
    endproperty
    a_pend_holds: assert property (p_pend_holds) else $error("pending event vanished");

    property p_idle_high;
        (pend_ff == '0) |-> irq_n_o;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("request active with nothing pending");

    property p_remote_ebit;
        (remote_ebit_err_stb && rx_event_int_enable_ff[P_REMOTE_EBIT - RX_BASE] && !int_suspend_ff)
            |=> pend_ff[P_REMOTE_EBIT] && !irq_n_o;
    endproperty
    a_remote_ebit: assert property (p_remote_ebit) else $error("remote e-bit error not latched");

    property p_ts16;
        (edge_bus.rise[E_TS16] && rx_event_int_enable_ff[P_TS16 - RX_BASE] && !int_suspend_ff)
            |=> pend_ff[P_TS16] && !irq_n_o;
    endproperty
    a_ts16: assert property (p_ts16) else $error("timeslot 16 alarm not latched");

    property p_lcv_err;
        (lcv_err_stb && rx_event_int_enable_ff[P_LCV_ERR - RX_BASE] && !int_suspend_ff)
            |=> pend_ff[P_LCV_ERR] && !irq_n_o;
    endproperty
    a_lcv_err: assert property (p_lcv_err) else $error("line code error not latched");

    property p_prbs_err;
        (prbs_bit_err_stb && rx_event_int_enable_ff[P_PRBS_ERR - RX_BASE] && !int_suspend_ff)
            |=> pend_ff[P_PRBS_ERR] && !irq_n_o;
    endproperty
    a_prbs_err: assert property (p_prbs_err) else $error("test pattern bit error not latched");

    property p_aux;
        (edge_bus.rise[E_AUX] && rx_event_int_enable_ff[P_AUX - RX_BASE] && !int_suspend_ff)
            |=> pend_ff[P_AUX] && !irq_n_o;
    endproperty
    a_aux: assert property (p_aux) else $error("aux pattern rise not latched");

    property p_rai;
        (edge_bus.rise[E_RAI] && rx_event_int_enable_ff[P_RAI - RX_BASE] && !int_suspend_ff)
            |=> pend_ff[P_RAI] && !irq_n_o;
    endproperty
    a_rai: assert property (p_rai) else $error("remote alarm not latched");

    property p_fas_ovf;
        (fas_cnt_ovf_stb && counter_overflow_int_enable_ff[P_FAS_OVF - CNT_BASE] && !int_suspend_ff)
            |=> pend_ff[P_FAS_OVF] && !irq_n_o;
    endproperty
    a_fas_ovf: assert property (p_fas_ovf) else $error("frame error counter overflow not latched");

    property p_ebit_ovf;
        (ebit_cnt_ovf_stb && counter_overflow_int_enable_ff[P_EBIT_OVF - CNT_BASE] && !int_suspend_ff)
            |=> pend_ff[P_EBIT_OVF] && !irq_n_o;
    endproperty
    a_ebit_ovf: assert property (p_ebit_ovf) else $error("e-bit counter overflow not latched");

    property p_prbs_mf;
        (prbs_mf_cnt_ovf_stb && counter_overflow_int_enable_ff[P_PRBS_MF - CNT_BASE] && !int_suspend_ff)
            |=> pend_ff[P_PRBS_MF] && !irq_n_o;
    endproperty
    a_prbs_mf: assert property (p_prbs_mf) else $error("pattern multiframe overflow not latched");

    property p_five_sec;
        (!five_second_flag ##1 five_second_flag && misc_event_int_enable_ff[P_FIVE_SEC - MISC_BASE]
            && !int_suspend_ff) |=> pend_ff[P_FIVE_SEC] && !irq_n_o;
    endproperty
    a_five_sec: assert property (p_five_sec) else $error("five-second rise missed");

    c_frame_err: cover property (frame_err_stb && rx_event_int_enable_ff[P_FRAME_ERR - RX_BASE] ##1 !irq_n_o);
    c_ack: cover property (!irq_n_o ##1 ack_clr ##1 irq_n_o);
    c_set_on_ack: cover property (ack_clr && (|set_vec));
    c_suspend: cover property (int_suspend_ff && (|src_all));
endmodule : eiml_int_mask

`default_nettype wire

// ==== hw/eiml_pkg.sv ====
// constants shared by the e1 interrupt mask logic: register map, field
// positions, reset values and the layout of the pending-event vector.
// assumes an 8-bit register port in the ref_clk domain addressing page 1.
`default_nettype none

package eiml_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SRC_W = 24;
    localparam int EDGE_W = 10;

    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h19;
    localparam logic [ADDR_W-1:0] RX_MASK_ADDR = 8'h1B;
    localparam logic [ADDR_W-1:0] CNT_MASK_ADDR = 8'h1C;
    localparam logic [ADDR_W-1:0] MISC_MASK_ADDR = 8'h1D;

    localparam int CTRL_SUSPEND_BIT = 6;
    localparam int CTRL_ACK_BIT = 5;
    localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CNT_MASK_USED = 8'hDF;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    // pending vector: rx mask at the top, counter mask in the middle
    localparam int RX_BASE = 16;
    localparam int CNT_BASE = 8;
    localparam int MISC_BASE = 0;

    localparam int P_FRAME_ERR = RX_BASE + 7;
    localparam int P_LOCAL_CRC = RX_BASE + 6;
    localparam int P_REMOTE_EBIT = RX_BASE + 5;
    localparam int P_TS16 = RX_BASE + 4;
    localparam int P_LCV_ERR = RX_BASE + 3;
    localparam int P_PRBS_ERR = RX_BASE + 2;
    localparam int P_AUX = RX_BASE + 1;
    localparam int P_RAI = RX_BASE + 0;
    localparam int P_FAS_OVF = CNT_BASE + 7;
    localparam int P_EBIT_OVF = CNT_BASE + 4;
    localparam int P_LCV_WRAP = CNT_BASE + 3;
    localparam int P_PRBS_WRAP = CNT_BASE + 2;
    localparam int P_PRBS_MF = CNT_BASE + 1;
    localparam int P_SPARE = CNT_BASE + 0;
    localparam int P_LINK_A = MISC_BASE + 7;
    localparam int P_ONE_SEC = MISC_BASE + 3;
    localparam int P_FIVE_SEC = MISC_BASE + 2;
    localparam int P_SIG = MISC_BASE + 0;

    // positions in the level vector fed to the rise detector
    localparam int E_TS16 = 0;
    localparam int E_AUX = 1;
    localparam int E_RAI = 2;
    localparam int E_LINK_A = 3;
    localparam int E_LINK_B = 4;
    localparam int E_LINK_C = 5;
    localparam int E_JITTER = 6;
    localparam int E_ONE_SEC = 7;
    localparam int E_FIVE_SEC = 8;
    localparam int E_ALARM_CRC = 9;
endpackage : eiml_pkg

`default_nettype wire

// ==== hw/eiml_edge_if.sv ====
// carrier between the interrupt mask top and its rise detector.
// assumes both ends run on ref_clk.
`default_nettype none

interface eiml_edge_if #(parameter int W = 1);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    modport src (output level, input rise);
    modport det (input level, output rise);
endinterface : eiml_edge_if

`default_nettype wire

// ==== hw/eiml_rise_det.sv ====
// zero-to-one detector for a vector of status levels.
// assumes levels come from logic on ref_clk, so no synchroniser is needed.
`default_nettype none

module eiml_rise_det #(parameter int W = 1)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    eiml_edge_if.det edge_io
);
    logic [W-1:0] prev_ff;
    logic armed_ff;

    // refuse a width the vector logic cannot serve
    if (W < 1)
    begin : g_bad_width
        $error("eiml_rise_det: W must be at least one");
    end

    // a level already high when reset lifts is not a rise
    assign edge_io.rise = edge_io.level & ~prev_ff & {W{armed_ff}};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prev_ff <= '0;
            armed_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= edge_io.level;
            armed_ff <= 1'b1;
        end
    end
endmodule : eiml_rise_det

`default_nettype wire

// ==== bench/eiml_host_model.sv ====
// host processor model: byte-wide register writes and reads on ref_clk.
// assumes the device takes a strobe at the rising edge where it is seen high,
// and that callers enter each task 10 ns after a rising edge.
`default_nettype none

module eiml_host_model
(
    input wire logic ref_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [eiml_pkg::ADDR_W-1:0] reg_addr,
    output logic [eiml_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [eiml_pkg::DATA_W-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import eiml_pkg::*;

    logic ack_ff = 1'b0;
    logic susp_ff = 1'b0;

    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // strobe held over one edge, then one idle cycle so strobes never retrigger in one step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #10;
        reg_wr = 1'b0;
        // released lines carry the inverse so a stale value is never mistaken for valid
        reg_addr = ~a;
        reg_wdata = ~d;
        @(posedge ref_clk);
        #10;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #10;
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(posedge ref_clk);
        #10;
    endtask : rd

    // control word keeps its other bits low; the acknowledge bit is flipped when toggle_ack is set, otherwise rewritten equal
    task automatic ctrl(input logic susp, input logic toggle_ack);
        if (toggle_ack)
            ack_ff = ~ack_ff;
        susp_ff = susp;
        wr(CTRL_ADDR, {1'b0, susp_ff, ack_ff, 5'h00});
    endtask : ctrl
endmodule : eiml_host_model

`default_nettype wire

// ==== bench/e1_interrupt_mask_logic_tb.sv ====
// self-checking bench for the interrupt mask block, host model on the register port.
// assumes the request pin answers at the same edge where an event is taken.
`default_nettype none

module e1_interrupt_mask_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import eiml_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b1;
    logic [SRC_W-1:0] ev = '0;
    logic reg_wr, reg_rd, irq_n_o, irq_oe;
    logic [ADDR_W-1:0] reg_addr, a;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rb, d, m;
    logic [ADDR_W-1:0] map_a [4] = '{CTRL_ADDR, RX_MASK_ADDR, CNT_MASK_ADDR, MISC_MASK_ADDR};
    int mismatches = 0;
    int cmp_count = 0;

    always #50 ref_clk = ~ref_clk;

    eiml_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // event vector follows the mask layout (rx bits 23-16, counter 15-8, misc 7-0) except ev[13], the spare nibble change
    eiml_int_mask dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .frame_err_stb(ev[23]), .local_crc_err_stb(ev[22]), .remote_ebit_err_stb(ev[21]),
        .ts16_alarm_indication(ev[20]), .lcv_err_stb(ev[19]), .prbs_bit_err_stb(ev[18]),
        .aux_pattern_flag(ev[17]), .remote_alarm_flag(ev[16]), .fas_cnt_ovf_stb(ev[15]),
        .crc_cnt_ovf_stb(ev[14]), .spare_nibble_chg_stb(ev[13]), .ebit_cnt_ovf_stb(ev[12]),
        .lcv_cnt_wrap_stb(ev[11]), .prbs_cnt_wrap_stb(ev[10]), .prbs_mf_cnt_ovf_stb(ev[9]),
        .spare_bit_chg_stb(ev[8]), .spare_bit_or_nibble_select(sel), .link_ctrl_a_irq(ev[7]),
        .link_ctrl_b_irq(ev[6]), .link_ctrl_c_irq(ev[5]), .jitter_near_limit(ev[4]),
        .one_second_flag(ev[3]), .five_second_flag(ev[2]), .remote_alarm_crc_flag(ev[1]),
        .sig_change_stb(ev[0]), .irq_n_o(irq_n_o), .irq_oe(irq_oe));

    function automatic logic [ADDR_W-1:0] addr_of(input int i);
        return (i >= RX_BASE) ? RX_MASK_ADDR : (i >= CNT_BASE) ? CNT_MASK_ADDR : MISC_MASK_ADDR;
    endfunction : addr_of

    function automatic logic [DATA_W-1:0] rb_exp(input logic [ADDR_W-1:0] ra, input logic [DATA_W-1:0] rd_v);
        case (ra)
            RX_MASK_ADDR, MISC_MASK_ADDR: return rd_v;
            CNT_MASK_ADDR: return rd_v & CNT_MASK_USED;
            default: return READ_IDLE;
        endcase
    endfunction : rb_exp

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            #10;
        end
    endtask : tick

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // a one-cycle pulse is both a strobe event and a rise of a level source
    task automatic fire(input int i);
        ev[i] = 1'b1;
        tick(1);
        ev[i] = 1'b0;
        tick(1);
    endtask : fire

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        #2000000;
        mismatches++;
        close_out();
    end

    initial
    begin
        void'($urandom(32'hDC9A));
        tick(8);
        rst_n = 1'b1;
        tick(1);
        chk({6'h00, irq_oe, irq_n_o}, 8'h03);
        foreach (map_a[k])
        begin
            host.rd(map_a[k], rb);
            chk(rb, MASK_RESET);
        end
        // random bytes to the masks and to unmapped neighbours 1A and 1E
        repeat (12)
        begin
            a = 8'($urandom_range(26, 30));
            d = 8'($urandom);
            host.wr(a, d);
            host.rd(a, rb);
            chk(rb, rb_exp(a, d));
        end
        foreach (map_a[k])
            host.wr(map_a[k], MASK_RESET);
        // every source but ev[13]: blocked with the other bits of its own mask open, then passed alone, then acknowledged
        for (int i = 0; i < SRC_W; i++)
        begin
            if (i == 13)
                continue;
            m = 8'h01 << (i % 8);
            host.wr(addr_of(i), ~m);
            fire(i);
            chk({7'h00, irq_n_o}, 8'h01);
            host.wr(addr_of(i), m);
            fire(i);
            chk({7'h00, irq_n_o}, 8'h00);
            chk({7'h00, irq_n_o}, 8'h00);
            host.ctrl(1'b0, 1'b1);
            chk({7'h00, irq_n_o}, 8'h01);
            host.wr(addr_of(i), MASK_RESET);
        end
        // spare bit or nibble change follows the selector
        host.wr(CNT_MASK_ADDR, 8'h01);
        sel = 1'b0;
        fire(8);
        chk({7'h00, irq_n_o}, 8'h01);
        fire(13);
        chk({7'h00, irq_n_o}, 8'h00);
        host.ctrl(1'b0, 1'b1);
        sel = 1'b1;
        fire(13);
        chk({7'h00, irq_n_o}, 8'h01);
        fire(8);
        chk({7'h00, irq_n_o}, 8'h00);
        host.ctrl(1'b0, 1'b1);
        host.wr(CNT_MASK_ADDR, MASK_RESET);
        // two pending sources: request stays low until both enables are dropped
        host.wr(RX_MASK_ADDR, 8'hFF);
        host.wr(MISC_MASK_ADDR, 8'hFF);
        fire(23);
        fire(0);
        host.wr(RX_MASK_ADDR, MASK_RESET);
        chk({7'h00, irq_n_o}, 8'h00);
        host.wr(MISC_MASK_ADDR, MASK_RESET);
        chk({7'h00, irq_n_o}, 8'h01);
        // suspend floats the pin and drops events
        host.wr(RX_MASK_ADDR, 8'hFF);
        host.ctrl(1'b1, 1'b0);
        chk({7'h00, irq_oe}, 8'h00);
        fire(22);
        host.rd(CTRL_ADDR, rb);
        chk(rb, {1'b0, host.susp_ff, host.ack_ff, 5'h00});
        host.ctrl(1'b0, 1'b0);
        chk({6'h00, irq_oe, irq_n_o}, 8'h03);
        fire(22);
        chk({7'h00, irq_n_o}, 8'h00);
        host.ctrl(1'b0, 1'b1);
        host.rd(CTRL_ADDR, rb);
        chk(rb, {1'b0, host.susp_ff, host.ack_ff, 5'h00});
        chk({7'h00, irq_n_o}, 8'h01);
        // a level that rose while masked is not replayed once its enable is set
        ev[P_ONE_SEC] = 1'b1;
        tick(2);
        host.wr(MISC_MASK_ADDR, 8'h08);
        chk({7'h00, irq_n_o}, 8'h01);
        ev[P_ONE_SEC] = 1'b0;
        tick(1);
        fire(P_ONE_SEC);
        chk({7'h00, irq_n_o}, 8'h00);
        host.wr(MISC_MASK_ADDR, MASK_RESET);
        chk({7'h00, irq_n_o}, 8'h01);
        // mid-run reset drops a pending event and all masks; host mirror is not used after this
        host.wr(RX_MASK_ADDR, 8'hFF);
        fire(P_FRAME_ERR);
        chk({7'h00, irq_n_o}, 8'h00);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
        chk({6'h00, irq_oe, irq_n_o}, 8'h03);
        foreach (map_a[k])
        begin
            host.rd(map_a[k], rb);
            chk(rb, MASK_RESET);
        end
        close_out();
    end
endmodule : e1_interrupt_mask_logic_tb

`default_nettype wire
